// *** hdl/lv_reset_pkg.sv ***
// Constants shared by the low-voltage reset control block
package lv_reset_pkg;
	// Register map
	localparam logic [7:0] STATUS_OFFSET = 8'h00;
	localparam logic [7:0] OPTION_OFFSET = 8'h01;
	localparam logic [7:0] MASK_OFFSET = 8'h02;
	localparam logic [7:0] EVENT_OFFSET = 8'h03;
	// Status register fields
	localparam int FLAG_BIT = 7;
	localparam int HOLD_BIT = 0;
	// Option register fields
	localparam int PWR_OFF_BIT = 0;
	localparam int RST_OFF_BIT = 1;
	localparam int STOP_KEEP_BIT = 2;
	localparam int LEVEL_SEL_BIT = 3;
	// Event register fields
	localparam int EV_TRIP_BIT = 0;
	localparam int EV_RESET_BIT = 1;
	localparam int EV_WAKE_BIT = 2;
	// Reset values
	localparam logic [7:0] OPTION_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] EVENT_RESET = 8'h00;
	// Reset vector locations fetched after a low-voltage reset
	localparam logic [15:0] VECTOR_HI_ADDR = 16'hFFFE;
	localparam logic [15:0] VECTOR_LO_ADDR = 16'hFFFF;
	// Fixed hold time on the reset pin after release
	localparam int PIN_HOLD_NS = 100;
	localparam int CLK_PERIOD_NS = 25;
	localparam int PIN_HOLD_CYCLES = (PIN_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lv_reset_pkg

// *** hdl/level_sync.sv ***
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module level_sync (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;

	// First stage read only by second stage
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : level_sync
`default_nettype wire

// *** hdl/pulse_stretch.sv ***
// Holds an output for a minimum count after its request drops
`timescale 1ns/100ps
`default_nettype none
module pulse_stretch #(
	parameter int HOLD = 4
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic req,
	output logic active
);
	localparam int CW = $clog2(HOLD + 1);
	logic [CW-1:0] count_reg;

	// Reload while request high, then count down
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			count_reg <= '0;
		end else if (req) begin
			count_reg <= CW'(HOLD);
		end else if (count_reg != '0) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	assign active = req || (count_reg != '0);
endmodule : pulse_stretch
`default_nettype wire

// *** hdl/low_voltage_reset_control.sv ***
// Low-voltage reset control around a supply comparator
`timescale 1ns/100ps
`default_nettype none
// Function
// (RULE_01) Monitor is on after reset with no software action.
// (RULE_02) Comparator watched only while monitor_power_off is clear.
// (RULE_03) Reset asserted on falling trip when reset generation enabled.
// (RULE_04) Stop mode monitoring needs stop_mode_keep; reset then ends stop.
// (RULE_05) trip_level_select set picks higher level, clear picks lower.
// (RULE_06) Power-on reset returns trip_level_select to the lower level.
// (RULE_07) Selecting higher level below its rising threshold resets at once.
// (RULE_08) After firing, hold reset until supply rises above rising level.
// (RULE_09) External active-low reset pin driven low during low-voltage reset.
// (RULE_10) Flag is 1 below falling, 0 above rising, else holds.
// (RULE_11) Any reset clears the below-trip flag.
// (RULE_12) Monitor never raises an interrupt request itself; here irq is driven from the masked event bits.
// (RULE_13) Polled use: power-off bit 0, reset-off bit 1, poll flag.
// (RULE_14) Forced reset use: clear both power-off and reset-off bits.
// (RULE_15) Wait mode keeps enabled monitor; its reset ends wait.
// (RULE_16) Reset ending stop restarts clocks and fetches reset vector.
// (RULE_17) Comparator outputs pass a two-stage synchroniser first.
module low_voltage_reset_control
	import lv_reset_pkg::*;
#(
	parameter int PIN_HOLD = PIN_HOLD_CYCLES
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic por_n,
	input wire logic below_falling_low,
	input wire logic above_rising_low,
	input wire logic below_falling_high,
	input wire logic above_rising_high,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rdata,
	output logic trip_level_select,
	output logic chip_reset,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	output logic mode_exit,
	output logic clock_restart,
	output logic [15:0] vector_addr,
	output logic irq
);
	typedef enum logic [2:0] {
		MON_IDLE = 3'b001,
		MON_ARMED = 3'b010,
		MON_HOLD = 3'b100
	} mon_state_type;

	mon_state_type state_reg;
	mon_state_type state_next;
	logic [7:0] option_reg;
	logic [7:0] mask_reg;
	logic [7:0] event_reg;
	logic level_reg;
	logic flag_reg;
	logic lvr_prev_reg;
	logic level_prev_reg;
	logic level_raised;
	logic fall_low_s;
	logic rise_low_s;
	logic fall_high_s;
	logic rise_high_s;
	logic below_fall;
	logic above_rise;
	logic monitor_on;
	logic reset_en;
	logic lv_reset;
	logic pin_active;
	logic [7:0] event_set;

	// Lower level, falling comparator
	level_sync u_sync_fl (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in(below_falling_low),
		.sync_out(fall_low_s)
	); // [RULE_17]
	// Lower level, rising comparator
	level_sync u_sync_rl (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in(above_rising_low),
		.sync_out(rise_low_s)
	); // [RULE_17]
	// Higher level, falling comparator
	level_sync u_sync_fh (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in(below_falling_high),
		.sync_out(fall_high_s)
	); // [RULE_17]
	// Higher level, rising comparator
	level_sync u_sync_rh (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in(above_rising_high),
		.sync_out(rise_high_s)
	); // [RULE_17]

	// Trip level choice
	assign below_fall = level_reg ? fall_high_s : fall_low_s; // [RULE_05]
	assign above_rise = level_reg ? rise_high_s : rise_low_s; // [RULE_05]
	assign trip_level_select = level_reg;

	// Monitoring enable including stop-mode gating
	assign monitor_on = !option_reg[PWR_OFF_BIT]
		&& (!stop_mode || option_reg[STOP_KEEP_BIT]); // [RULE_02] [RULE_04]
	assign reset_en = monitor_on && !option_reg[RST_OFF_BIT]; // [RULE_03]

	// Option register, cleared to monitor-on by the asynchronous reset only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			option_reg <= OPTION_RESET; // [RULE_01]
		end else if (wr_stb && addr == OPTION_OFFSET) begin
			option_reg <= {4'h0, 1'b0, wdata[STOP_KEEP_BIT:0]};
		end
	end

	// Trip level cleared only by the asynchronous reset and power-on reset
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			level_reg <= 1'b0;
		end else if (!por_n) begin
			level_reg <= 1'b0; // [RULE_06]
		end else if (wr_stb && addr == OPTION_OFFSET) begin
			level_reg <= wdata[LEVEL_SEL_BIT]; // [RULE_05]
		end
	end

	// Delayed level to spot a switch to the higher level
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			level_prev_reg <= 1'b0;
		end else begin
			level_prev_reg <= level_reg;
		end
	end
	// One cycle after the higher level is chosen
	assign level_raised = level_reg && !level_prev_reg; // [RULE_07]

	// Below-trip flag with hysteresis
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_reg <= 1'b0; // [RULE_11]
		end else if (!por_n || lv_reset) begin
			flag_reg <= 1'b0; // [RULE_11]
		end else if (monitor_on && below_fall) begin
			flag_reg <= 1'b1; // [RULE_10]
		end else if (monitor_on && above_rise) begin
			flag_reg <= 1'b0; // [RULE_10]
		end
	end

	// Reset state machine
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			MON_IDLE: begin
				if (reset_en) begin
					state_next = MON_ARMED;
				end
			end
			MON_ARMED: begin
				if (!reset_en) begin
					state_next = MON_IDLE;
				end else if (below_fall || (level_raised && !above_rise)) begin
					// Falling trip, or higher level chosen below its rising point
					state_next = MON_HOLD; // [RULE_03] [RULE_07]
				end
			end
			MON_HOLD: begin
				if (above_rise) begin
					state_next = MON_ARMED; // [RULE_08]
				end
			end
			default: state_next = MON_IDLE;
		endcase
	end

	// State register; power-on reset abandons the hold
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= MON_IDLE;
		end else if (!por_n) begin
			state_reg <= MON_IDLE; // [RULE_07]
		end else begin
			state_reg <= state_next;
		end
	end

	assign lv_reset = (state_reg == MON_HOLD); // [RULE_08]
	assign chip_reset = lv_reset;

	// Pin stays low a short while after release
	pulse_stretch #(.HOLD(PIN_HOLD)) u_pin (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.req(lv_reset),
		.active(pin_active)
	);
	assign reset_pin_out = 1'b0; // [RULE_09]
	assign reset_pin_oe = pin_active; // [RULE_09]

	// Low-power mode exit on low-voltage reset
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			lvr_prev_reg <= 1'b0;
		end else begin
			lvr_prev_reg <= lv_reset;
		end
	end
	assign mode_exit = lv_reset && (wait_mode || stop_mode); // [RULE_15] [RULE_04]
	assign clock_restart = lvr_prev_reg && !lv_reset; // [RULE_16]

	// Vector fetch address: first word while held, second after restart
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			vector_addr <= VECTOR_HI_ADDR;
		end else if (por_n && state_next == MON_HOLD) begin
			// Loaded with the hold so it already stands on entry
			vector_addr <= VECTOR_HI_ADDR; // [RULE_16]
		end else if (clock_restart) begin
			vector_addr <= VECTOR_LO_ADDR; // [RULE_16]
		end
	end

	// Sticky event bits; set wins over read clear
	always_comb begin
		event_set = 8'h00;
		event_set[EV_TRIP_BIT] = monitor_on && below_fall && !flag_reg;
		event_set[EV_RESET_BIT] = lv_reset && !lvr_prev_reg;
		event_set[EV_WAKE_BIT] = mode_exit;
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			event_reg <= EVENT_RESET;
		end else if (rd_stb && addr == EVENT_OFFSET) begin
			event_reg <= event_set;
		end else begin
			event_reg <= event_reg | event_set;
		end
	end

	// Mask register
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_reg <= MASK_RESET;
		end else if (wr_stb && addr == MASK_OFFSET) begin
			mask_reg <= wdata & 8'h07;
		end
	end

	// Summary line kept off the chip's own request lines
	assign irq = |(event_reg & mask_reg); // [RULE_12]

	// Read data one cycle after strobe
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (rd_stb) begin
			unique case (addr)
				STATUS_OFFSET: begin
					rdata <= {flag_reg, 6'h00, lv_reset};
				end
				OPTION_OFFSET: begin
					rdata <= {4'h0, level_reg, option_reg[STOP_KEEP_BIT:0]};
				end
				MASK_OFFSET: begin
					rdata <= mask_reg;
				end
				EVENT_OFFSET: begin
					rdata <= event_reg;
				end
				default: begin
					rdata <= 8'h00;
				end
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule : low_voltage_reset_control
`default_nettype wire

// *** testbench/lv_reset_sva.sv ***
// Port checker for the low-voltage reset control
`timescale 1ns/100ps
`default_nettype none
module lv_reset_sva
	import lv_reset_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic por_n,
	input wire logic wait_mode,
	input wire logic stop_mode,
	input wire logic [7:0] addr,
	input wire logic rd_stb,
	input wire logic [7:0] rdata,
	input wire logic trip_level_select,
	input wire logic chip_reset,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic mode_exit,
	input wire logic clock_restart,
	input wire logic [15:0] vector_addr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Pin and mode exit follow the held reset
	chk_pin_low: assert property (chip_reset |-> reset_pin_oe && !reset_pin_out)
		else $error("reset pin not driven low");
	chk_pin_hold: assert property ($fell(chip_reset) |-> reset_pin_oe ##[1:8] !reset_pin_oe)
		else $error("reset pin hold wrong");
	chk_exit_mode: assert property (mode_exit == (chip_reset && (wait_mode || stop_mode)))
		else $error("mode exit mismatch");
	// Restart and vector sequence after release
	chk_restart_pulse: assert property ($fell(chip_reset) |-> ##[0:1] clock_restart)
		else $error("no clock restart");
	chk_restart_one: assert property (clock_restart |=> !clock_restart)
		else $error("restart pulse too long");
	chk_vector_hold: assert property (chip_reset |-> vector_addr == VECTOR_HI_ADDR)
		else $error("vector wrong in reset");
	chk_vector_next: assert property (clock_restart |-> ##[0:1] vector_addr == VECTOR_LO_ADDR)
		else $error("vector not advanced");
	// Read data timing, status layout and trip level after power-on reset
	chk_rd_idle: assert property (!$past(rd_stb) |-> rdata == 8'h00)
		else $error("read data outside slot");
	chk_stat_fmt: assert property (rd_stb && addr == STATUS_OFFSET |=> rdata[6:1] == 6'h00 && rdata[HOLD_BIT] == $past(chip_reset))
		else $error("status layout wrong");
	chk_flag_clear: assert property (rd_stb && addr == STATUS_OFFSET && chip_reset && $past(chip_reset) |=> !rdata[FLAG_BIT])
		else $error("flag set during reset");
	chk_por_level: assert property (!por_n |=> !trip_level_select)
		else $error("level kept over power-on");
endmodule : lv_reset_sva
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the low-voltage reset control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import lv_reset_pkg::*;
	logic sys_clk = 0, arst_n = 0, por_n = 1, wait_mode = 0, stop_mode = 0;
	logic below_falling_low = 0, above_rising_low = 1;
	logic below_falling_high = 0, above_rising_high = 1;
	logic wr_stb = 0, rd_stb = 0, trip_level_select, chip_reset;
	logic reset_pin_out, reset_pin_oe, mode_exit, clock_restart, irq;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
	logic [15:0] vector_addr;
	int n_mismatch = 0, checks_done = 0;
	low_voltage_reset_control DUT (.sys_clk, .arst_n, .por_n,
		.below_falling_low, .above_rising_low, .below_falling_high,
		.above_rising_high, .wait_mode, .stop_mode, .addr, .wdata, .wr_stb,
		.rd_stb, .rdata, .trip_level_select, .chip_reset, .reset_pin_out,
		.reset_pin_oe, .mode_exit, .clock_restart, .vector_addr, .irq);
	always #12.5 sys_clk = ~sys_clk;
	task ck(input logic [15:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : ck
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task wr(input logic [7:0] a, d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1 rv = rdata;
	endtask : rd
	// Comparator levels, then time for the synchroniser
	task sup(input logic bfl, arl, bfh, arh);
		@(posedge sys_clk);
		below_falling_low <= bfl;
		above_rising_low <= arl;
		below_falling_high <= bfh;
		above_rising_high <= arh;
		cyc(6);
	endtask : sup
	task t_defaults;
		rd(STATUS_OFFSET); ck(rv, 8'h00);
		rd(OPTION_OFFSET); ck(rv, OPTION_RESET);
		wr(8'h10, 8'hFF);
		rd(8'h10); ck(rv, 8'h00);
		ck(irq, 1'b0);
		ck(trip_level_select, 1'b0);
	endtask : t_defaults
	task t_forced;
		wr(OPTION_OFFSET, 8'h00);
		wait_mode <= 1'b1;
		sup(1, 0, 1, 0);
		ck(chip_reset, 1'b1);
		ck(reset_pin_oe, 1'b1);
		ck(mode_exit, 1'b1);
		ck(vector_addr, VECTOR_HI_ADDR);
		sup(0, 0, 1, 0);
		ck(chip_reset, 1'b1);
		rd(STATUS_OFFSET); ck(rv, 8'h01);
		wait_mode <= 1'b0;
		sup(0, 1, 0, 1);
		ck(chip_reset, 1'b0);
		ck(vector_addr, VECTOR_LO_ADDR);
		cyc(PIN_HOLD_CYCLES);
		ck(reset_pin_oe, 1'b0);
	endtask : t_forced
	task t_polled;
		rd(EVENT_OFFSET);
		wr(MASK_OFFSET, 8'h01);
		cyc(1);
		ck(irq, 1'b0);
		wr(OPTION_OFFSET, 8'h02);
		sup(1, 0, 1, 0);
		ck(chip_reset, 1'b0);
		ck(irq, 1'b1);
		rd(STATUS_OFFSET); ck(rv, 8'h80);
		sup(0, 0, 1, 0);
		rd(STATUS_OFFSET); ck(rv, 8'h80);
		sup(0, 1, 0, 1);
		rd(STATUS_OFFSET); ck(rv, 8'h00);
		rd(EVENT_OFFSET); ck(rv[EV_TRIP_BIT], 1'b1);
		ck(irq, 1'b0);
		wr(MASK_OFFSET, 8'h00);
		sup(1, 0, 1, 0);
		ck(irq, 1'b0);
		sup(0, 1, 0, 1);
		rd(EVENT_OFFSET);
	endtask : t_polled
	task t_off_stop;
		wr(OPTION_OFFSET, 8'h01);
		sup(1, 0, 1, 0);
		ck(chip_reset, 1'b0);
		rd(STATUS_OFFSET); ck(rv, 8'h00);
		sup(0, 1, 0, 1);
		stop_mode <= 1'b1;
		wr(OPTION_OFFSET, 8'h00);
		sup(1, 0, 1, 0);
		ck(chip_reset, 1'b0);
		sup(0, 1, 0, 1);
		wr(OPTION_OFFSET, 8'h04);
		sup(1, 0, 1, 0);
		ck(mode_exit, 1'b1);
		sup(0, 1, 0, 1);
		stop_mode <= 1'b0;
	endtask : t_off_stop
	task t_high;
		wr(OPTION_OFFSET, 8'h00);
		sup(0, 1, 0, 0);
		ck(chip_reset, 1'b0);
		wr(OPTION_OFFSET, 8'h08);
		cyc(4);
		ck(trip_level_select, 1'b1);
		ck(chip_reset, 1'b1);
		por_n <= 1'b0;
		cyc(3);
		por_n <= 1'b1;
		cyc(3);
		ck(trip_level_select, 1'b0);
		ck(chip_reset, 1'b0);
	endtask : t_high
	task give_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		arst_n <= 1'b1;
		t_defaults;
		t_forced;
		t_polled;
		t_off_stop;
		t_high;
		give_verdict;
	end
	// Watchdog against a hang
	initial begin
		#200000;
		n_mismatch++;
		give_verdict;
	end
endmodule : tb_top
bind low_voltage_reset_control lv_reset_sva chk (.sys_clk, .arst_n, .por_n,
	.wait_mode, .stop_mode, .addr, .rd_stb, .rdata, .trip_level_select,
	.chip_reset, .reset_pin_out, .reset_pin_oe, .mode_exit, .clock_restart,
	.vector_addr);
`default_nettype wire
